// ### rtl/rtes_defines.svh
// Offsets, field positions, reset values and timing counts of the transmit error block
`ifndef RTES_DEFINES_SVH
`define RTES_DEFINES_SVH

`define RTES_A_STATUS     8'h00
`define RTES_A_CTRL       8'h04
`define RTES_A_COUNT      8'h08
`define RTES_A_IRQ_STAT   8'h0C
`define RTES_A_IRQ_EN     8'h10
`define RTES_A_IRQ_CLR    8'h14

`define RTES_ST_BM_BUSY   14
`define RTES_ST_FETCH     13
`define RTES_ST_UNDER     12
`define RTES_ST_EMPTY     11
`define RTES_ST_CODE_HI   10
`define RTES_ST_CODE_LO   8
`define RTES_ST_TX_ACTIVE 4

`define RTES_CTRL_CARRIER 0
`define RTES_CTRL_START   1

`define RTES_IRQ_FETCH    0
`define RTES_IRQ_UNDER    1
`define RTES_IRQ_EMPTY    2
`define RTES_IRQ_ACT      3
`define RTES_NIRQ         4

`define RTES_CODE_RST     3'h0
`define RTES_COUNT_RST    16'h0000
`define RTES_CLK_NS       20
`define RTES_BYTE_NS      1600
`define RTES_BYTE_CYC     (`RTES_BYTE_NS / `RTES_CLK_NS)

`endif

// ### rtl/rtes_pkg.sv
// Types shared by the transmit error block
package rtes_pkg;
    typedef logic [7:0]  rtes_addr_t;
    typedef logic [31:0] rtes_word_t;
    typedef logic [15:0] rtes_count_t;

    typedef struct packed {
        logic       valid;
        logic       rd_err;
        logic [7:0] data;
    } rtes_bm_s;

    typedef struct packed {
        logic       strobe;
        logic [7:0] data;
    } rtes_tx_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] code;
    } rtes_fault_s;

    typedef enum logic [1:0] {
        RTES_IDLE = 2'b01,
        RTES_SEND = 2'b10
    } rtes_state_e;
endpackage : rtes_pkg

// ### rtl/rtes_irq.sv
// Sticky interrupt status, enable and write-one-to-clear logic
`timescale 1ns/10ps
`include "rtes_defines.svh"
module rtes_irq (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`RTES_NIRQ-1:0]  evt,
    input  wire logic                   en_wr,
    input  wire logic                   clr_wr,
    input  wire logic [`RTES_NIRQ-1:0]  wdata,
    output logic      [`RTES_NIRQ-1:0]  status,
    output logic      [`RTES_NIRQ-1:0]  enable,
    output logic                        irq
);
    genvar i;
    generate
        for (i = 0; i < `RTES_NIRQ; i++) begin : g_bit
            // An event in the clearing cycle survives
            always_ff @(posedge clk) begin
                if (!rst_n)
                    status[i] <= 1'b0;
                else if (evt[i])
                    status[i] <= 1'b1;
                else if (clr_wr && wdata[i])
                    status[i] <= 1'b0;
            end
            always_ff @(posedge clk) begin
                if (!rst_n)
                    enable[i] <= 1'b0;
                else if (en_wr)
                    enable[i] <= wdata[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(status & enable);
    end
endmodule : rtes_irq

// ### rtl/rtes_top.sv
// Transmit path error and status flags with APB register access
// What this block does
// [R01] Read failure sets fetch-fault flag, aborts transmission
// [R02] Late data sets underrun flag, aborts transmission
// [R03] Start with zero byte count sets flag
// [R04] Fault code valid only while fault interrupt
// [R05] Writing carrier-drive one clears fault code
// [R06] Flags and code read-only, reset to zero
`timescale 1ns/10ps
`include "rtes_defines.svh"
module rtes_top (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire rtes_pkg::rtes_addr_t PADDR,
    input  wire rtes_pkg::rtes_word_t PWDATA,
    output rtes_pkg::rtes_word_t      PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire rtes_pkg::rtes_bm_s   BM_IN,
    input  wire logic                 BM_BUSY,
    output logic                      BM_REQ,
    output rtes_pkg::rtes_tx_s        TX_OUT,
    input  wire rtes_pkg::rtes_fault_s ACT_FAULT,
    output logic                      CARRIER_ON,
    output logic                      TX_ACTIVE,
    output logic                      IRQ
);
    import rtes_pkg::*;

    localparam logic [7:0] BYTE_LAST = 8'(`RTES_BYTE_CYC - 1);

    rtes_state_e            state_reg;
    rtes_count_t            count_reg;
    rtes_count_t            left_reg;
    logic [7:0]             timer_reg;
    logic                   fetch_reg;
    logic                   under_reg;
    logic                   empty_reg;
    logic [2:0]             code_reg;
    logic                   carrier_reg;
    rtes_word_t             prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    rtes_tx_s               tx_reg;
    logic [`RTES_NIRQ-1:0]  irq_evt;
    logic [`RTES_NIRQ-1:0]  irq_status;
    logic [`RTES_NIRQ-1:0]  irq_enable;
    logic                   irq_out;
    logic                   setup;
    logic                   wr;
    logic                   start;
    logic                   carrier_wr1;
    logic                   sending;
    logic                   fetch_evt;
    logic                   under_evt;
    logic                   empty_evt;
    logic                   fault_irq;
    logic                   mapped;
    rtes_word_t             rd_mux;

    assign setup       = PSEL && !PENABLE;
    assign wr          = PSEL && PENABLE && PWRITE && pready_reg;
    assign start       = wr && PADDR == `RTES_A_CTRL && PWDATA[`RTES_CTRL_START];
    assign carrier_wr1 = wr && PADDR == `RTES_A_CTRL && PWDATA[`RTES_CTRL_CARRIER];
    assign sending     = state_reg == RTES_SEND;
    // Read failure outranks lateness when both hit the same cycle
    assign fetch_evt   = sending && BM_IN.rd_err; // R01
    assign under_evt   = sending && !BM_IN.rd_err && !BM_IN.valid
                         && timer_reg == BYTE_LAST; // R02
    assign empty_evt   = start && !sending && count_reg == `RTES_COUNT_RST; // R03
    assign fault_irq   = irq_status[`RTES_IRQ_ACT];

    assign irq_evt[`RTES_IRQ_FETCH] = fetch_evt;
    assign irq_evt[`RTES_IRQ_UNDER] = under_evt;
    assign irq_evt[`RTES_IRQ_EMPTY] = empty_evt;
    assign irq_evt[`RTES_IRQ_ACT]   = ACT_FAULT.valid;

    rtes_irq u_irq (
        .clk    (CLK),
        .rst_n  (RST_N),
        .evt    (irq_evt),
        .en_wr  (wr && PADDR == `RTES_A_IRQ_EN),
        .clr_wr (wr && PADDR == `RTES_A_IRQ_CLR),
        .wdata  (PWDATA[`RTES_NIRQ-1:0]),
        .status (irq_status),
        .enable (irq_enable),
        .irq    (irq_out)
    );

    // Transmit sequencer: one byte per slot from the buffer manager
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= RTES_IDLE;
            left_reg  <= `RTES_COUNT_RST;
            timer_reg <= 8'h00;
        end else begin
            case (state_reg)
                RTES_IDLE: begin
                    timer_reg <= 8'h00;
                    if (start && count_reg != `RTES_COUNT_RST) begin
                        state_reg <= RTES_SEND;
                        left_reg  <= count_reg;
                    end
                end
                RTES_SEND: begin
                    if (fetch_evt || under_evt) begin
                        state_reg <= RTES_IDLE; // R01 R02
                    end else if (BM_IN.valid) begin
                        timer_reg <= 8'h00;
                        left_reg  <= left_reg - 16'h0001;
                        if (left_reg == 16'h0001)
                            state_reg <= RTES_IDLE;
                    end else begin
                        timer_reg <= timer_reg + 8'h01;
                    end
                end
                default: state_reg <= RTES_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            tx_reg <= '0;
        else begin
            tx_reg.strobe <= sending && BM_IN.valid && !BM_IN.rd_err;
            if (sending && BM_IN.valid && !BM_IN.rd_err)
                tx_reg.data <= BM_IN.data;
        end
    end

    // Flags hold until the next start; a fresh error in that cycle wins
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fetch_reg <= 1'b0;
            under_reg <= 1'b0;
            empty_reg <= 1'b0;
        end else begin
            fetch_reg <= fetch_evt || (fetch_reg && !start); // R01
            under_reg <= under_evt || (under_reg && !start); // R02
            empty_reg <= empty_evt || (empty_reg && !start); // R03
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            code_reg <= `RTES_CODE_RST; // R06
        else if (ACT_FAULT.valid)
            code_reg <= ACT_FAULT.code;
        else if (carrier_wr1)
            code_reg <= `RTES_CODE_RST; // R05
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count_reg   <= `RTES_COUNT_RST;
            carrier_reg <= 1'b0;
        end else if (wr && PADDR == `RTES_A_COUNT) begin
            count_reg <= PWDATA[15:0];
        end else if (wr && PADDR == `RTES_A_CTRL) begin
            carrier_reg <= PWDATA[`RTES_CTRL_CARRIER];
        end
    end

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (PADDR)
            `RTES_A_STATUS: begin
                rd_mux[`RTES_ST_BM_BUSY]   = BM_BUSY;
                rd_mux[`RTES_ST_FETCH]     = fetch_reg;
                rd_mux[`RTES_ST_UNDER]     = under_reg;
                rd_mux[`RTES_ST_EMPTY]     = empty_reg;
                // Code is masked while its interrupt is down
                rd_mux[`RTES_ST_CODE_HI:`RTES_ST_CODE_LO] =
                    fault_irq ? code_reg : `RTES_CODE_RST; // R04
                rd_mux[`RTES_ST_TX_ACTIVE] = sending;
            end
            `RTES_A_CTRL:     rd_mux[`RTES_CTRL_CARRIER] = carrier_reg;
            `RTES_A_COUNT:    rd_mux[15:0] = count_reg;
            `RTES_A_IRQ_STAT: rd_mux[`RTES_NIRQ-1:0] = irq_status;
            `RTES_A_IRQ_EN:   rd_mux[`RTES_NIRQ-1:0] = irq_enable;
            `RTES_A_IRQ_CLR:  rd_mux = '0;
            default:          mapped = 1'b0;
        endcase
    end

    // Answer in the first access cycle; status is a read-only word
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup)
                prdata_reg <= PWRITE ? '0 : rd_mux; // R06
        end
    end

    assign PRDATA     = prdata_reg;
    assign PREADY     = pready_reg;
    assign PSLVERR    = pslverr_reg;
    assign BM_REQ     = sending;
    assign TX_OUT     = tx_reg;
    assign CARRIER_ON = carrier_reg;
    assign TX_ACTIVE  = sending;
    assign IRQ        = irq_out;

    chk_fetch_abort: assert property (@(posedge CLK) disable iff (!RST_N) // R01
        fetch_evt |=> fetch_reg && state_reg == RTES_IDLE)
        else $error("read failure did not flag and abort");

    chk_under_abort: assert property (@(posedge CLK) disable iff (!RST_N) // R02
        sending && !BM_IN.valid && !BM_IN.rd_err [*1] ##0 timer_reg == BYTE_LAST
        |=> under_reg && !TX_ACTIVE)
        else $error("late byte did not flag underrun");

    chk_empty_start: assert property (@(posedge CLK) disable iff (!RST_N) // R03
        start && !sending && count_reg == 16'h0000 |=> empty_reg && !TX_ACTIVE)
        else $error("empty start not flagged");

    chk_code_masked: assert property (@(posedge CLK) disable iff (!RST_N) // R04
        PREADY && !PWRITE && PADDR == `RTES_A_STATUS && !$past(fault_irq)
        |-> PRDATA[`RTES_ST_CODE_HI:`RTES_ST_CODE_LO] == 3'h0)
        else $error("fault code visible without its interrupt");

    chk_code_clear: assert property (@(posedge CLK) disable iff (!RST_N) // R05
        carrier_wr1 && !ACT_FAULT.valid |=> code_reg == 3'h0)
        else $error("carrier write did not clear fault code");

    chk_flags_ro: assert property (@(posedge CLK) disable iff (!RST_N) // R06
        wr && PADDR == `RTES_A_STATUS |=> fetch_reg == $past(fetch_reg)
        || $past(fetch_evt) || $past(start))
        else $error("status write changed a flag");

    chk_timer_bound: assert property (@(posedge CLK) disable iff (!RST_N) // R02
        sending |-> timer_reg <= BYTE_LAST)
        else $error("byte slot timer ran past its deadline");

    chk_fault_irq: assert property (@(posedge CLK) disable iff (!RST_N) // R04
        ACT_FAULT.valid ##1 irq_enable[`RTES_IRQ_ACT] |=> IRQ)
        else $error("enabled fault did not raise interrupt");
endmodule : rtes_top

// ### dv/rtes_bm_model.sv
// Behavioural buffer manager that feeds transmit bytes with a set latency or a read fault
`timescale 1ns/10ps
module rtes_bm_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bm_req,
    input  wire logic [7:0] delay,
    input  wire logic [7:0] err_at,
    output rtes_pkg::rtes_bm_s bm_out,
    output logic            busy
);
    import rtes_pkg::*;
    logic [7:0] wait_cnt;
    logic [7:0] idx;

    // Data toggles between bytes so a stale value is never mistaken for a new one
    always_ff @(posedge clk) begin
        busy          <= rst_n && bm_req;
        bm_out.valid  <= 1'b0;
        bm_out.rd_err <= 1'b0;
        bm_out.data   <= ~bm_out.data;
        if (!rst_n || !bm_req) begin
            wait_cnt <= 8'h00;
            idx      <= 8'h00;
            if (!rst_n) begin
                bm_out.data <= 8'hA5;
            end
        end else if (wait_cnt == delay) begin
            wait_cnt      <= 8'h00;
            idx           <= idx + 8'h01;
            bm_out.valid  <= (idx != err_at);
            bm_out.rd_err <= (idx == err_at);
            bm_out.data   <= 8'h30 + idx;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule : rtes_bm_model

// ### dv/tb_top.sv
// Register-level testbench of the transmit error block
`timescale 1ns/10ps
`include "rtes_defines.svh"
module tb_top;
    import rtes_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pslverr, pready, bm_busy, bm_req;
    logic        carrier_on, tx_active, irq, serr;
    rtes_addr_t  paddr;
    rtes_word_t  pwdata, prdata, q;
    rtes_bm_s    bm_in;
    rtes_tx_s    tx_out;
    rtes_fault_s fault;
    logic [7:0]  delay, err_at;
    int          fails, comparisons, strobes;
    logic [7:0]  last_data;

    rtes_top rtes_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BM_IN(bm_in), .BM_BUSY(bm_busy), .BM_REQ(bm_req),
        .TX_OUT(tx_out), .ACT_FAULT(fault), .CARRIER_ON(carrier_on),
        .TX_ACTIVE(tx_active), .IRQ(irq));
    rtes_bm_model rtes_bm_model_inst (.clk(clk), .rst_n(rst_n), .bm_req(bm_req),
        .delay(delay), .err_at(err_at), .bm_out(bm_in), .busy(bm_busy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (tx_out.strobe === 1'b1) begin
            strobes++;
            last_data = tx_out.data;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Master holds the request until pready is sampled high
    task automatic apb(input logic wr, input rtes_addr_t a, input rtes_word_t d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q       = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic start_tx(input logic [15:0] n);
        strobes = 0;
        apb(1'b1, `RTES_A_COUNT, {16'h0000, n});
        apb(1'b1, `RTES_A_CTRL, 32'h0000_0002);
    endtask : start_tx

    task automatic wait_idle();
        @(posedge clk);
        for (int i = 0; i < 2000 && tx_active !== 1'b0; i++) @(posedge clk);
        // The last strobe is counted at the edge where idle is seen; let it land
        @(posedge clk);
    endtask : wait_idle

    task automatic pulse_fault(input logic [2:0] code);
        @(posedge clk);
        fault <= '{1'b1, code};
        @(posedge clk);
        fault <= '0;
    endtask : pulse_fault

    task automatic complete_run();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (10000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        {rst_n, psel, penable, pwrite} = 4'h0;
        paddr  = '0;
        pwdata = '0;
        fault  = '0;
        delay  = 8'h02;
        err_at = 8'hFF;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 0);
        apb(1'b0, `RTES_A_IRQ_STAT, 0); chk(q, 0);
        apb(1'b1, `RTES_A_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 0);
        apb(1'b1, `RTES_A_IRQ_EN, 32'h0000_000F);
        // Start with nothing to send stays idle and flags the fault
        start_tx(16'h0000);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_0800);
        apb(1'b0, `RTES_A_IRQ_STAT, 0); chk(q, 32'h0000_0004);
        chk(irq, 1'b1);
        apb(1'b1, `RTES_A_IRQ_CLR, 32'h0000_000F);
        start_tx(16'h0003);
        wait_idle();
        chk(strobes, 3);
        chk(last_data, 8'h32);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 0);
        // Read fault on the second byte
        err_at <= 8'h01;
        start_tx(16'h0004);
        wait_idle();
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_2000);
        chk(strobes, 1);
        chk(last_data, 8'h30);
        // Latency past the byte deadline
        err_at <= 8'hFF;
        delay  <= 8'h5A;
        start_tx(16'h0002);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_4010);
        chk(bm_req, 1'b1);
        wait_idle();
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_1000);
        chk(strobes, 0);
        apb(1'b1, `RTES_A_IRQ_CLR, 32'h0000_000F);
        pulse_fault(3'h5);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_1500);
        chk(irq, 1'b1);
        apb(1'b1, `RTES_A_IRQ_CLR, 32'h0000_0008);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_1000);
        pulse_fault(3'h6);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_1600);
        apb(1'b1, `RTES_A_CTRL, 32'h0000_0001);
        apb(1'b0, `RTES_A_STATUS, 0); chk(q, 32'h0000_1000);
        apb(1'b0, `RTES_A_IRQ_STAT, 0); chk(q, 32'h0000_0008);
        chk(carrier_on, 1'b1);
        apb(1'b1, `RTES_A_IRQ_STAT, 32'h0000_0000);
        apb(1'b0, `RTES_A_IRQ_STAT, 0); chk(q, 32'h0000_0008);
        apb(1'b0, 8'h20, 0); chk(serr, 1'b1);
        chk(q, 32'h0000_0000);
        complete_run();
    end
endmodule : tb_top
